// ### rtl/cic_stage.sv
// block sum or cascaded integrator-comb step for one slot and channel
`timescale 1ns/1ps
`default_nettype none
module cic_stage
    import slot_pkg::*;
(
    input  wire logic [DW-1:0]                sample_in,
    input  wire logic [ORD_W-1:0]             order_in,
    input  wire logic                         dump_in,
    input  wire logic [CIC_MAX-1:0][DW-1:0]   integ_in,
    input  wire logic [CIC_MAX-1:0][DW-1:0]   comb_in,
    output logic      [CIC_MAX-1:0][DW-1:0]   integ_out,
    output logic      [CIC_MAX-1:0][DW-1:0]   comb_out,
    output logic      [DW-1:0]                result_out
);
    logic [DW-1:0] acc;
    logic [DW-1:0] c;
    logic [DW-1:0] y;

    always_comb begin
        integ_out  = integ_in;
        comb_out   = comb_in;
        acc        = sample_in;
        c          = '0;
        y          = '0;
        result_out = '0;
        // order zero is a plain block sum
        if (order_in == '0) begin
            result_out   = integ_in[0] + sample_in;
            integ_out[0] = dump_in ? '0 : result_out;
        end else begin
            for (int k = 0; k < CIC_MAX; k++) begin
                if (k < int'(order_in)) begin
                    integ_out[k] = integ_in[k] + acc;
                    acc          = integ_out[k];
                end
            end
            c = acc;
            if (dump_in) begin
                for (int k = 0; k < CIC_MAX; k++) begin
                    if (k < int'(order_in)) begin
                        y           = c - comb_in[k];
                        comb_out[k] = c;
                        c           = y;
                    end
                end
            end
            result_out = c;
        end
    end
endmodule : cic_stage
`default_nettype wire

// ### rtl/sat_pack.sv
// shift, saturate and byte-order one value for the queue
`timescale 1ns/1ps
`default_nettype none
module sat_pack
    import slot_pkg::*;
(
    input  wire logic [DW-1:0]                 value_in,
    input  wire logic [SH_W-1:0]               shift_in,
    input  wire logic [SZ_W-1:0]               size_in,
    output logic      [UNIT_BYTES-1:0][7:0]    bytes_out,
    output logic      [SZ_W-1:0]               count_out
);
    logic [DW-1:0] sh;
    logic [DW-1:0] v;
    logic [SZ_W-1:0] n;

    always_comb begin
        n = (size_in > SZ_W'(UNIT_BYTES)) ? SZ_W'(UNIT_BYTES) : size_in;
        sh = value_in >> shift_in;
        v  = sh;
        // saturate when bits sit above the width
        if (n < SZ_W'(UNIT_BYTES) && (sh >> (8 * n)) != '0) begin
            v = ~(SAT_MAX << (8 * n));
        end
        bytes_out = '0;
        case (n)
            3'd1: bytes_out[0] = v[7:0];
            3'd2: bytes_out = {16'h0000, v[7:0], v[15:8]};
            3'd3: bytes_out = {8'h00, v[23:16], v[7:0], v[15:8]};
            3'd4: bytes_out = {v[23:16], v[31:24], v[7:0], v[15:8]};
            default: bytes_out = '0;
        endcase
        count_out = n;
    end
endmodule : sat_pack
`default_nettype wire

// ### rtl/slot_decim_writer.sv
// per-slot accumulate, decimate, result registers and packet queue
`timescale 1ns/1ps
`default_nettype none
module slot_decim_writer
    import slot_pkg::*;
#(
    parameter int NS = 2,
    parameter int SW = 16
) (
    input  wire logic                             CLOCK_IN,
    input  wire logic                             NRST_IN,
    input  wire logic                             PULSE_VALID_IN,
    input  wire logic                             PULSE_SIGN_SELECT_IN,
    input  wire logic [CH_N-1:0][SW-1:0]          PULSE_DATA_IN,
    input  wire logic                             SLOT_END_IN,
    input  wire logic [3:0]                       SLOT_IDX_IN,
    input  wire logic [CH_N-1:0][DW-1:0]          AMBIENT_IN,
    input  wire logic                             PERIOD_END_IN,
    input  wire logic [NS-1:0]                    SLOT_EN_IN,
    input  wire logic [NS-1:0]                    CH2_EN_IN,
    input  wire logic [NS-1:0]                    SKIP_EN_IN,
    input  wire logic [NS-1:0]                    FREEZE_IN,
    input  wire logic [NS-1:0][DF_W-1:0]          DECIM_FACTOR_IN,
    input  wire logic [NS-1:0][ORD_W-1:0]         CIC_ORDER_IN,
    input  wire logic [NS-1:0][SH_W-1:0]          AMB_SHIFT_IN,
    input  wire logic [NS-1:0][SH_W-1:0]          SIG_SHIFT_IN,
    input  wire logic [NS-1:0][SZ_W-1:0]          AMB_SIZE_IN,
    input  wire logic [NS-1:0][SZ_W-1:0]          SIG_SIZE_IN,
    input  wire logic                             STATUS_EN_IN,
    input  wire logic [7:0]                       STATUS_BYTE_IN,
    input  wire logic                             FIFO_RD_IN,
    input  wire logic                             OVERRUN_CLR_IN,
    input  wire logic                             UNDERRUN_CLR_IN,
    output logic      [NS-1:0]                    SLOT_RUN_OUT,
    output logic      [NS-1:0]                    DATA_IRQ_OUT,
    output logic      [NS-1:0][CH_N-1:0][DW-1:0]  AMB_RESULT_OUT,
    output logic      [NS-1:0][CH_N-1:0][DW-1:0]  SIG_RESULT_OUT,
    output logic      [7:0]                       FIFO_DATA_OUT,
    output logic      [CNT_W-1:0]                 FIFO_COUNT_OUT,
    output logic                                  QUEUE_OVERRUN_FLAG_OUT,
    output logic                                  QUEUE_UNDERRUN_FLAG_OUT
);
    localparam int STG_N = NS * CH_N * 2 * UNIT_BYTES + 1;
    localparam int STG_W = $clog2(STG_N + 1);

    typedef struct packed {
        logic [CH_N-1:0][DW-1:0]                    pos;
        logic [CH_N-1:0][DW-1:0]                    neg;
        logic [NS-1:0][CH_N-1:0][CIC_MAX-1:0][DW-1:0] integ;
        logic [NS-1:0][CH_N-1:0][CIC_MAX-1:0][DW-1:0] comb;
        logic [NS-1:0][CH_N-1:0][DW-1:0]            amb_sum;
        logic [NS-1:0][CH_N-1:0][DW-1:0]            amb_int;
        logic [NS-1:0][CH_N-1:0][DW-1:0]            sig_int;
        logic [NS-1:0][CH_N-1:0][DW-1:0]            amb_host;
        logic [NS-1:0][CH_N-1:0][DW-1:0]            sig_host;
        logic [NS-1:0][DF_W-1:0]                    dcnt;
        logic [NS-1:0][DF_W-1:0]                    pcnt;
        logic [NS-1:0]                              run;
        logic [NS-1:0]                              irq;
        logic [STG_N-1:0][7:0]                      stg;
        logic [STG_W-1:0]                           stg_cnt;
        logic [STG_W-1:0]                           cp_idx;
        logic [STG_W-1:0]                           cp_len;
        commit_e                                    fsm;
        logic [FIFO_DEPTH-1:0][7:0]                 mem;
        logic [PTR_W-1:0]                           wp;
        logic [PTR_W-1:0]                           rp;
        logic [CNT_W-1:0]                           cnt;
        logic [7:0]                                 rdata;
        logic                                       ovf;
        logic                                       unf;
    } st_s;

    st_s st_q;
    st_s st_d;

    logic [CH_N-1:0][DW-1:0]              sig_val;
    logic [CH_N-1:0][CIC_MAX-1:0][DW-1:0] integ_n;
    logic [CH_N-1:0][CIC_MAX-1:0][DW-1:0] comb_n;
    logic [CH_N-1:0][DW-1:0]              sig_dec;
    logic [CH_N*2-1:0][DW-1:0]            unit_val;
    logic [CH_N*2-1:0][SH_W-1:0]          unit_sh;
    logic [CH_N*2-1:0][SZ_W-1:0]          unit_sz;
    logic [CH_N*2-1:0][UNIT_BYTES-1:0][7:0] unit_bytes;
    logic [CH_N*2-1:0][SZ_W-1:0]          unit_cnt;
    logic [NS-1:0]                        slot_hit;
    logic                                 dump;
    logic [ORD_W-1:0]                     ord;

    always_comb begin
        slot_hit = '0;
        for (int s = 0; s < NS; s++) begin
            slot_hit[s] = SLOT_END_IN && (SLOT_IDX_IN == 4'(s));
        end
    end

    always_comb begin
        dump = 1'b0;
        ord  = '0;
        for (int s = 0; s < NS; s++) begin
            if (slot_hit[s]) begin
                // emit after factor plus one executions; skip slots emit each run
                dump = SKIP_EN_IN[s] || (st_q.dcnt[s] == DECIM_FACTOR_IN[s]);
                ord  = (CIC_ORDER_IN[s] > ORD_W'(CIC_MAX)) ? ORD_W'(CIC_MAX) : CIC_ORDER_IN[s];
            end
        end
    end

    genvar gc;
    generate
        for (gc = 0; gc < CH_N; gc++) begin : g_ch
            // signal from the two sums; clip to zero
            assign sig_val[gc] = (st_q.pos[gc] > st_q.neg[gc]) ?
                                 st_q.pos[gc] - st_q.neg[gc] : '0;
            // state chosen by the slot that ends
            cic_stage u_cic (
                .sample_in  (sig_val[gc]),
                .order_in   (ord),
                .dump_in    (dump),
                .integ_in   (st_q.integ[SLOT_IDX_IN[$clog2(NS)-1:0]][gc]),
                .comb_in    (st_q.comb[SLOT_IDX_IN[$clog2(NS)-1:0]][gc]),
                .integ_out  (integ_n[gc]),
                .comb_out   (comb_n[gc]),
                .result_out (sig_dec[gc])
            );
            // ambient unit before signal unit, channel one first
            // ambient block sum taken from registered state, so no path loops through st_d
            assign unit_val[gc*2]   = st_q.amb_sum[SLOT_IDX_IN[$clog2(NS)-1:0]][gc] +
                                      (AMBIENT_IN[gc][DW-1] ? '0 : AMBIENT_IN[gc]);
            assign unit_val[gc*2+1] = sig_dec[gc];
            assign unit_sh[gc*2]    = AMB_SHIFT_IN[SLOT_IDX_IN[$clog2(NS)-1:0]];
            assign unit_sh[gc*2+1]  = SIG_SHIFT_IN[SLOT_IDX_IN[$clog2(NS)-1:0]];
            assign unit_sz[gc*2]    = AMB_SIZE_IN[SLOT_IDX_IN[$clog2(NS)-1:0]];
            assign unit_sz[gc*2+1]  = SIG_SIZE_IN[SLOT_IDX_IN[$clog2(NS)-1:0]];
            sat_pack u_amb (
                .value_in  (unit_val[gc*2]),
                .shift_in  (unit_sh[gc*2]),
                .size_in   (unit_sz[gc*2]),
                .bytes_out (unit_bytes[gc*2]),
                .count_out (unit_cnt[gc*2])
            );
            sat_pack u_sig (
                .value_in  (unit_val[gc*2+1]),
                .shift_in  (unit_sh[gc*2+1]),
                .size_in   (unit_sz[gc*2+1]),
                .bytes_out (unit_bytes[gc*2+1]),
                .count_out (unit_cnt[gc*2+1])
            );
        end
    endgenerate

    always_comb begin
        logic [DW:0]      sum;
        logic [DW-1:0]    amb_c;
        logic [STG_W-1:0] n;
        logic [15:0]      need;
        logic             wr;
        logic             rd;
        sum   = '0;
        amb_c = '0;
        n     = '0;
        need  = '0;
        wr    = 1'b0;
        rd    = 1'b0;
        st_d  = st_q;
        st_d.irq = '0;
        if (PULSE_VALID_IN) begin
            for (int c = 0; c < CH_N; c++) begin
                // sign select picks the sum; saturate, never wrap
                if (PULSE_SIGN_SELECT_IN) begin
                    sum = {1'b0, st_q.neg[c]} + (DW + 1)'(PULSE_DATA_IN[c]);
                    st_d.neg[c] = sum[DW] ? SAT_MAX : sum[DW-1:0];
                end else begin
                    sum = {1'b0, st_q.pos[c]} + (DW + 1)'(PULSE_DATA_IN[c]);
                    st_d.pos[c] = sum[DW] ? SAT_MAX : sum[DW-1:0];
                end
            end
        end
        for (int s = 0; s < NS; s++) begin
            if (slot_hit[s]) begin
                st_d.pos  = '0;
                st_d.neg  = '0;
                st_d.dcnt[s] = dump ? '0 : st_q.dcnt[s] + DF_W'(1);
                for (int c = 0; c < CH_N; c++) begin
                    st_d.integ[s][c] = integ_n[c];
                    st_d.comb[s][c]  = comb_n[c];
                    // negative ambient clips to zero; ambient block sum
                    amb_c = AMBIENT_IN[c][DW-1] ? '0 : AMBIENT_IN[c];
                    st_d.amb_sum[s][c] = dump ? '0 : st_q.amb_sum[s][c] + amb_c;
                    if (dump) begin
                        st_d.amb_int[s][c] = st_q.amb_sum[s][c] + amb_c;
                        st_d.sig_int[s][c] = sig_dec[c];
                    end
                end
                if (dump) begin
                    // results, staged bytes and data pulse together
                    st_d.irq[s] = 1'b1;
                    n = st_q.stg_cnt;
                    for (int u = 0; u < CH_N * 2; u++) begin
                        if (u < 2 || CH2_EN_IN[s]) begin
                            for (int b = 0; b < UNIT_BYTES; b++) begin
                                if (b < int'(unit_cnt[u]) && int'(n) < STG_N) begin
                                    st_d.stg[n] = unit_bytes[u][b];
                                    n = n + STG_W'(1);
                                end
                            end
                        end
                    end
                    st_d.stg_cnt = n;
                end
            end
            // freeze holds the host copy only
            if (!FREEZE_IN[s]) begin
                st_d.amb_host[s] = st_d.amb_int[s];
                st_d.sig_host[s] = st_d.sig_int[s];
            end
        end
        // one byte per read, oldest first
        if (FIFO_RD_IN) begin
            if (st_q.cnt != '0) begin
                rd = 1'b1;
                st_d.rdata = st_q.mem[st_q.rp];
                st_d.rp    = st_q.rp + PTR_W'(1);
            end else begin
                // empty read answers ff and flags
                st_d.rdata = EMPTY_BYTE;
            end
        end
        case (st_q.fsm)
            ST_IDLE: begin
                if (PERIOD_END_IN) begin
                    // room for every active slot, emitting or not
                    for (int s = 0; s < NS; s++) begin
                        if (SLOT_EN_IN[s]) begin
                            need = need + 16'(AMB_SIZE_IN[s]) + 16'(SIG_SIZE_IN[s]);
                            if (CH2_EN_IN[s]) begin
                                need = need + 16'(AMB_SIZE_IN[s]) + 16'(SIG_SIZE_IN[s]);
                            end
                        end
                        // skip slots run when the period count meets the factor
                        st_d.pcnt[s] = (st_q.pcnt[s] >= DECIM_FACTOR_IN[s]) ?
                                       '0 : st_q.pcnt[s] + DF_W'(1);
                        st_d.run[s]  = !SKIP_EN_IN[s] ||
                                       (st_d.pcnt[s] == DECIM_FACTOR_IN[s]);
                    end
                    // status byte last, whichever slots ran
                    if (STATUS_EN_IN) begin
                        need = need + 16'd1;
                        st_d.stg[st_q.stg_cnt] = STATUS_BYTE_IN;
                    end
                    if (16'(st_q.cnt) + need <= 16'(FIFO_DEPTH)
                            && st_q.stg_cnt + STG_W'(STATUS_EN_IN) != '0) begin
                        st_d.cp_len = st_q.stg_cnt + STG_W'(STATUS_EN_IN);
                        st_d.cp_idx = '0;
                        st_d.fsm    = ST_COPY;
                    end else begin
                        st_d.stg_cnt = '0;
                    end
                end
            end
            ST_COPY: begin
                wr = 1'b1;
                st_d.mem[st_q.wp] = st_q.stg[st_q.cp_idx];
                st_d.wp     = st_q.wp + PTR_W'(1);
                st_d.cp_idx = st_q.cp_idx + STG_W'(1);
                if (st_d.cp_idx == st_q.cp_len) begin
                    st_d.stg_cnt = '0;
                    st_d.fsm     = ST_IDLE;
                end
            end
            default: st_d.fsm = ST_IDLE;
        endcase
        st_d.cnt = st_q.cnt + CNT_W'(wr) - CNT_W'(rd);
        // a set in the clearing cycle wins
        st_d.ovf = (st_q.ovf && !OVERRUN_CLR_IN) || (st_q.fsm == ST_IDLE && PERIOD_END_IN
                   && 16'(st_q.cnt) + need > 16'(FIFO_DEPTH));
        st_d.unf = (st_q.unf && !UNDERRUN_CLR_IN) || (FIFO_RD_IN && st_q.cnt == '0);
    end

    always_ff @(posedge CLOCK_IN) begin
        if (!NRST_IN) begin
            st_q     <= '0;
            st_q.run <= '1;
            st_q.fsm <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign SLOT_RUN_OUT            = st_q.run;
    assign DATA_IRQ_OUT            = st_q.irq;
    assign AMB_RESULT_OUT          = st_q.amb_host;
    assign SIG_RESULT_OUT          = st_q.sig_host;
    assign FIFO_DATA_OUT           = st_q.rdata;
    assign FIFO_COUNT_OUT          = st_q.cnt;
    assign QUEUE_OVERRUN_FLAG_OUT  = st_q.ovf;
    assign QUEUE_UNDERRUN_FLAG_OUT = st_q.unf;

    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!NRST_IN);

    a_underrun_read: assert property (FIFO_RD_IN && FIFO_COUNT_OUT == '0 |=>
        FIFO_DATA_OUT == EMPTY_BYTE && QUEUE_UNDERRUN_FLAG_OUT) else $error("empty read");
    a_count_bound: assert property (FIFO_COUNT_OUT <= CNT_W'(FIFO_DEPTH))
        else $error("queue count above depth");
    a_overrun_drop: assert property (st_q.fsm == ST_IDLE && PERIOD_END_IN
        && QUEUE_OVERRUN_FLAG_OUT == 1'b0 && !OVERRUN_CLR_IN ##1 QUEUE_OVERRUN_FLAG_OUT
        |-> st_q.fsm == ST_IDLE) else $error("partial packet on overrun");
    a_read_pops: assert property (FIFO_RD_IN && FIFO_COUNT_OUT != '0 && st_q.fsm == ST_IDLE
        |=> FIFO_COUNT_OUT == $past(FIFO_COUNT_OUT) - CNT_W'(1)) else $error("read not popped");
    a_freeze_hold: assert property (FREEZE_IN[0] && $past(FREEZE_IN[0])
        |-> $stable(SIG_RESULT_OUT[0])) else $error("frozen copy changed");
    a_irq_on_dump: assert property (slot_hit[0] && dump |=> DATA_IRQ_OUT[0])
        else $error("data pulse missing");
    a_irq_needs_dump: assert property (DATA_IRQ_OUT[0] |-> $past(slot_hit[0] && dump))
        else $error("data pulse without output");
    a_pos_sat: assert property (PULSE_VALID_IN && !PULSE_SIGN_SELECT_IN && !slot_hit[0]
        && !slot_hit[NS-1] |=> st_q.pos[0] >= $past(st_q.pos[0])) else $error("sum wrapped");
    a_run_noskip: assert property (PERIOD_END_IN && st_q.fsm == ST_IDLE && !SKIP_EN_IN[0]
        |=> SLOT_RUN_OUT[0]) else $error("plain slot not run");
    a_copy_done: assert property (st_q.fsm == ST_COPY |-> ##[1:40] st_q.fsm == ST_IDLE)
        else $error("commit stuck");

    c_commit: cover property (st_q.fsm == ST_COPY ##1 st_q.fsm == ST_IDLE);
    c_overrun: cover property ($rose(QUEUE_OVERRUN_FLAG_OUT));
    c_underrun: cover property ($rose(QUEUE_UNDERRUN_FLAG_OUT));
    c_skip_run: cover property (SKIP_EN_IN[0] && $rose(SLOT_RUN_OUT[0]));
endmodule : slot_decim_writer
`default_nettype wire

// ### rtl/slot_pkg.sv
// shared constants and types for the slot decimation and queue writer
package slot_pkg;
    localparam int        DW         = 32;
    localparam int        CH_N       = 2;
    localparam int        CIC_MAX    = 4;
    localparam int        DF_W       = 11;
    localparam int        ORD_W      = 3;
    localparam int        SH_W       = 5;
    localparam int        SZ_W       = 3;
    localparam int        UNIT_BYTES = 4;
    localparam int        FIFO_DEPTH = 512;
    localparam int        PTR_W      = 9;
    localparam int        CNT_W      = 10;
    localparam logic [7:0] EMPTY_BYTE = 8'hff;
    localparam logic [DW-1:0] SAT_MAX = 32'hffffffff;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_COPY = 2'b10
    } commit_e;
endpackage : slot_pkg

// ### verif/host_reader.sv
// host model that pops queue bytes one read at a time
`timescale 1ns/1ps
`default_nettype none
module host_reader (
    input  wire logic       clk_in,
    input  wire logic [7:0] data_in,
    output logic            rd_out
);
    initial rd_out = 1'b0;
    // reads one byte per call
    // the caller loops over the bytes of a packet, one call per byte
    task automatic read_byte(output logic [7:0] b);
        @(posedge clk_in) rd_out <= 1'b1;
        @(posedge clk_in) rd_out <= 1'b0;
        #1 b = data_in;
    endtask : read_byte
endmodule : host_reader
`default_nettype wire

// ### verif/slot_decim_writer_test.sv
// directed bench for the slot decimation and queue writer
`timescale 1ns/1ps
`default_nettype none
module slot_decim_writer_test;
    import slot_pkg::*;
    logic clk = 0, nrst = 0, pv = 0, ps = 0, se = 0, pe = 0, rd, oc = 0, uc = 0;
    logic [1:0][15:0] pd = '0;
    logic [1:0][31:0] amb = '0;
    logic [1:0] sen = 2'h1, c2 = 2'h1, skip = 2'h0, frz = 2'h0, run, irq;
    logic [1:0][10:0] df = '0;
    logic [1:0][2:0] ord = '0, asz = 6'h01, ssz = 6'h02;
    logic [1:0][4:0] ash = '0, ssh = 10'h001;
    logic [1:0][1:0][31:0] ares, sres;
    logic [7:0] fdat, b;
    logic [9:0] fcnt;
    logic ovf, unf;
    logic [7:0] exp_b [7] = '{8'hff, 8'h1f, 8'h80, 8'h00, 8'h00, 8'h00, 8'h5a};
    int err_count = 0, tests_run = 0, cyc = 0;
    always #5 clk = ~clk;
    slot_decim_writer DUT (.CLOCK_IN(clk), .NRST_IN(nrst), .PULSE_VALID_IN(pv),
        .PULSE_SIGN_SELECT_IN(ps), .PULSE_DATA_IN(pd), .SLOT_END_IN(se),
        .SLOT_IDX_IN(4'h0), .AMBIENT_IN(amb), .PERIOD_END_IN(pe), .SLOT_EN_IN(sen),
        .CH2_EN_IN(c2), .SKIP_EN_IN(skip), .FREEZE_IN(frz), .DECIM_FACTOR_IN(df),
        .CIC_ORDER_IN(ord), .AMB_SHIFT_IN(ash), .SIG_SHIFT_IN(ssh), .AMB_SIZE_IN(asz),
        .SIG_SIZE_IN(ssz), .STATUS_EN_IN(1'b1), .STATUS_BYTE_IN(8'h5a), .FIFO_RD_IN(rd),
        .OVERRUN_CLR_IN(oc), .UNDERRUN_CLR_IN(uc), .SLOT_RUN_OUT(run), .DATA_IRQ_OUT(irq),
        .AMB_RESULT_OUT(ares), .SIG_RESULT_OUT(sres), .FIFO_DATA_OUT(fdat),
        .FIFO_COUNT_OUT(fcnt), .QUEUE_OVERRUN_FLAG_OUT(ovf), .QUEUE_UNDERRUN_FLAG_OUT(unf));
    host_reader HOST (.clk_in(clk), .data_in(fdat), .rd_out(rd));
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done
    task automatic pulse(input logic s, input logic [15:0] a, input logic [15:0] c);
        @(posedge clk) begin
            pv <= 1'b1; ps <= s; pd[0] <= a; pd[1] <= c;
        end
        @(posedge clk) pv <= 1'b0;
    endtask : pulse
    // ch2 gets the swapped pair and negated ambient, so it clips to zero
    task automatic slot(input logic [15:0] p, input logic [15:0] n, input logic [31:0] a,
                        input logic ei);
        pulse(1'b0, p, n);
        pulse(1'b1, n, p);
        @(posedge clk) begin
            se <= 1'b1; amb[0] <= a; amb[1] <= -a;
        end
        @(posedge clk) se <= 1'b0;
        #1 check("data_irq", 32'(irq[0]), 32'(ei));
        @(posedge clk);
    endtask : slot
    task automatic period();
        @(posedge clk) pe <= 1'b1;
        @(posedge clk) pe <= 1'b0;
        repeat (40) @(posedge clk);
        #1;
    endtask : period
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk) #1 check("slot_run", 32'(run), 32'h3);
        check("count", 32'(fcnt), 32'h0);
        slot(16'h4000, 16'h0100, 32'h12c, 1'b1);
        #1 check("sig0", sres[0][0], 32'h3f00);
        check("sig1", sres[0][1], 32'h0);
        check("amb1", ares[0][1], 32'h0);
        check("amb0", ares[0][0], 32'h12c);
        period();
        check("count", 32'(fcnt), 32'h7);
        // expected bytes cover saturation, shift, byte order and channel order
        for (int i = 0; i < 7; i++) begin
            HOST.read_byte(b);
            check("byte", 32'(b), 32'(exp_b[i]));
        end
        check("count", 32'(fcnt), 32'h0);
        HOST.read_byte(b);
        check("empty", 32'(b), 32'hff);
        check("underrun", 32'(unf), 32'h1);
        @(posedge clk) uc <= 1'b1;
        @(posedge clk) uc <= 1'b0;
        #1 check("underrun", 32'(unf), 32'h0);
        // 73 periods of 7 bytes leave 1 byte free; the 74th must drop whole
        for (int k = 0; k < 74; k++) begin
            slot(16'h4000, 16'h0100, 32'h12c, 1'b1);
            period();
        end
        check("count", 32'(fcnt), 32'd511);
        check("overrun", 32'(ovf), 32'h1);
        df[0] <= 11'h1;
        slot(16'd10, 16'd0, 32'h0, 1'b0);
        slot(16'd20, 16'd0, 32'h0, 1'b1);
        #1 check("sum", sres[0][0], 32'd30);
        df[0] <= 11'h0;
        frz[0] <= 1'b1;
        slot(16'd5, 16'd0, 32'h0, 1'b1);
        #1 check("frozen", sres[0][0], 32'd30);
        frz[0] <= 1'b0;
        ord[0] <= 3'h1;
        df[0] <= 11'h1;
        slot(16'd10, 16'd0, 32'h0, 1'b0);
        slot(16'd20, 16'd0, 32'h0, 1'b1);
        slot(16'd5, 16'd0, 32'h3, 1'b0);
        slot(16'd7, 16'd0, 32'h4, 1'b1);
        #1 check("cic", sres[0][0], 32'd12);
        check("amb_sum", ares[0][0], 32'd7);
        skip[0] <= 1'b1;
        period();
        check("skip_run", 32'(run[0]), 32'h1);
        period();
        check("skip_idle", 32'(run[0]), 32'h0);
        slot(16'd9, 16'd0, 32'h0, 1'b1);
        test_done();
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            test_done();
        end
    end
endmodule : slot_decim_writer_test
`default_nettype wire
